// ===== src/ams_device.sv
// Notes on behaviour
// - Power-up: calibrate, find address, busy high
// - Reset by supply, general call, key+bit
// - Full reset clears config, recalibrates
// - Soft reset keeps flags and key
// - Powers up manual, channel 0, fast oscillator
// - Manual conversions started by host transactions
// - Modes 000b/001b manual single channel
// - Host stops single channel with NACK, STOP
// - Modes 100b/101b need start then read
// - Host aborts sequence before mode change
// - Register read ends the auto sequence
// - Manual mode ignores divider, fast oscillator
// - Rate set by 18 SCL periods plus k; the code returns one result per SCL period
// - Stretch SCL low to 1.8 us
// - No stretch when low time suffices
// - Two-channel sequence alternates, channel zero first
// - Autonomous mode raises alert on threshold crossing
// - Mode 110b selects autonomous
// - Host starts first conversion only
// - Alert needs channel and block enables
// - Writing 03h clears latched flags
// - Host aborts before config changes
// - Pre-alert keeps sixteen newest, then stops
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ams_device (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Link to host
  ams_link_if.dev          lnk,
  // Analog result stand-ins
  input  wire logic [11:0] adc_in0,
  input  wire logic [11:0] adc_in1,
  // Status
  output logic             fast_osc_used
);
  typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_MAN, ST_AUTO} ams_state_t;
  typedef struct packed {
    ams_state_t  st;
    logic [15:0] cnt;
    logic [2:0]  mode;
    logic [1:0]  seq_ch;
    logic        seq_on;
    logic        osc;
    logic [7:0]  div;
    logic [2:0]  buf_mode;
    logic        cmp_en;
    logic [1:0]  alert_ch;
    logic [11:0] thr_hi;
    logic [11:0] thr_lo;
    logic [7:0]  hys;
    logic [1:0]  flag_lo;
    logic [1:0]  flag_hi;
    logic        key_ok;
    logic        next_ch;
    logic        scl_low_q;
    logic        scl_hold;
    logic        sample_vld;
    logic        sample_ch;
    logic [11:0] sample;
    logic        busy;
    logic        alert;
    logic [7:0]  rdata;
    logic [3:0]  wp;
    logic        fast_osc;
    logic [15:0][11:0] buf_mem;  // Pre-alert ring of results
  } ams_dev_t;
  ams_dev_t r;
  ams_dev_t next_r;
  logic [11:0] cur;
  logic        hi_x;
  logic        lo_x;

  // Next state
  always_comb begin
    next_r = r;
    next_r.sample_vld = 1'b0;
    next_r.scl_low_q = lnk.scl_low;
    cur = r.next_ch ? adc_in1 : adc_in0;
    hi_x = cur > r.thr_hi;
    lo_x = cur < r.thr_lo;
    if (lnk.power_cycle || (lnk.gen_call && lnk.gen_byte == ams_pkg::SOFT_RESET_BYTE)) begin
      next_r = '0;
      next_r.st = ST_CAL;
      next_r.busy = 1'b1;
      next_r.osc = 1'b1;
      next_r.seq_ch = ams_pkg::SEQ_CH_RESET;
    end else if (lnk.wr && lnk.addr == ams_pkg::REG_DEV_RESET && lnk.wdata[0] && r.key_ok) begin
      next_r = '0;
      next_r.st = ST_IDLE;
      next_r.osc = 1'b1;
      next_r.seq_ch = ams_pkg::SEQ_CH_RESET;
      next_r.flag_lo = r.flag_lo;
      next_r.flag_hi = r.flag_hi;
      next_r.key_ok = r.key_ok;
      next_r.buf_mem = r.buf_mem;
    end else begin
      // Register writes
      if (lnk.wr && r.st != ST_CAL) begin
        case (lnk.addr)
          ams_pkg::REG_MODE:      next_r.mode = lnk.wdata[2:0];
          ams_pkg::REG_SEQ_CH:    next_r.seq_ch = lnk.wdata[1:0];
          ams_pkg::REG_SEQUENCE_START_BIT: if (lnk.wdata[0]) next_r.seq_on = 1'b1;
          ams_pkg::REG_SEQUENCE_ABORT_BIT: if (lnk.wdata[0]) next_r.seq_on = 1'b0;
          ams_pkg::REG_OSC:       next_r.osc = lnk.wdata[0];
          ams_pkg::REG_DIV:       next_r.div = lnk.wdata;
          ams_pkg::REG_BUF_MODE:  next_r.buf_mode = lnk.wdata[2:0];
          ams_pkg::REG_CMP_EN:    next_r.cmp_en = lnk.wdata[0];
          ams_pkg::REG_ALERT_CH:  next_r.alert_ch = lnk.wdata[1:0];
          ams_pkg::REG_THR_HI:    next_r.thr_hi = {lnk.wdata, 4'h0};
          ams_pkg::REG_THR_LO:    next_r.thr_lo = {lnk.wdata, 4'h0};
          ams_pkg::REG_HYS:       next_r.hys = lnk.wdata;
          ams_pkg::REG_FLAG_LO:   if (lnk.wdata == ams_pkg::FLAG_CLEAR_VAL) next_r.flag_lo = '0;
          ams_pkg::REG_FLAG_HI:   if (lnk.wdata == ams_pkg::FLAG_CLEAR_VAL) next_r.flag_hi = '0;
          ams_pkg::REG_WRITE_KEY: next_r.key_ok = (lnk.wdata == ams_pkg::WRITE_KEY_VAL);
          default: ;
        endcase
      end
      // Register reads
      if (lnk.rd) begin
        case (lnk.addr)
          ams_pkg::REG_MODE:     next_r.rdata = {5'h00, r.mode};
          ams_pkg::REG_FLAG_LO:  next_r.rdata = {6'h00, r.flag_lo};
          ams_pkg::REG_FLAG_HI:  next_r.rdata = {6'h00, r.flag_hi};
          ams_pkg::REG_SEQ_CH:   next_r.rdata = {6'h00, r.seq_ch};
          ams_pkg::REG_BUF_MODE: next_r.rdata = {5'h00, r.buf_mode};
          ams_pkg::REG_HYS:      next_r.rdata = r.hys;
          default:               next_r.rdata = 8'h00;
        endcase
        if (r.mode[2] && !r.mode[1]) next_r.seq_on = 1'b0;
      end
      case (r.st)
        ST_CAL: begin
          next_r.busy = 1'b1;
          next_r.cnt = r.cnt + 16'h0001;
          if (r.cnt >= 16'(ams_pkg::CAL_CYC)) begin
            next_r.st = ST_IDLE;
            next_r.busy = 1'b0;
            next_r.cnt = '0;
          end
        end
        ST_IDLE: begin
          // Single-channel manual modes always start on channel zero
          next_r.next_ch = r.mode[2] && (r.seq_ch == 2'h2);
          if (lnk.data_rd && (r.mode[2:1] == 2'b00 ||
              (r.mode[2:1] == 2'b10 && r.seq_on))) begin
            next_r.st = ST_MAN;
            next_r.cnt = '0;
          end else if (r.mode == ams_pkg::MODE_AUTONOMOUS && r.seq_on) begin
            next_r.st = ST_AUTO;
            next_r.cnt = '0;
            next_r.wp = '0;
          end
        end
        ST_MAN: begin
          // Fast oscillator regardless of divider
          next_r.cnt = r.cnt + 16'h0001;
          if (lnk.scl_low && !r.scl_low_q) next_r.cnt = '0;
          // Hold SCL low until minimum low time elapsed
          next_r.scl_hold = lnk.scl_low &&
            (r.cnt < 16'(ams_pkg::SCL_LOW_MIN_CYC - 1));
          if (!lnk.scl_low && r.scl_low_q) begin
            next_r.sample_vld = 1'b1;
            next_r.sample = cur;
            next_r.sample_ch = r.next_ch;
            if (r.mode[2] && r.seq_ch == 2'h3) next_r.next_ch = !r.next_ch;
          end
          if (lnk.nack_stop && !r.mode[2]) begin
            next_r.st = ST_IDLE;
            next_r.scl_hold = 1'b0;
          end
          if (r.mode[2] && !next_r.seq_on) begin
            next_r.st = ST_IDLE;
            next_r.scl_hold = 1'b0;
          end
        end
        ST_AUTO: begin
          next_r.cnt = r.cnt + 16'h0001;
          if (r.cnt >= 16'(ams_pkg::AUTO_PERIOD_CYC) + {8'h00, r.div}) begin
            next_r.cnt = '0;
            next_r.buf_mem[r.wp] = cur;
            next_r.wp = r.wp + 4'h1;
            if (r.seq_ch == 2'h3) next_r.next_ch = !r.next_ch;
            if (r.cmp_en && r.alert_ch[r.next_ch] && (hi_x || lo_x)) begin
              // Set wins over a clear in the same cycle
              next_r.flag_hi[r.next_ch] = next_r.flag_hi[r.next_ch] | hi_x;
              next_r.flag_lo[r.next_ch] = next_r.flag_lo[r.next_ch] | lo_x;
              next_r.alert = 1'b1;
              next_r.st = ST_IDLE;
              next_r.seq_on = 1'b0;
            end
          end
          if (!next_r.seq_on || r.mode != ams_pkg::MODE_AUTONOMOUS) next_r.st = ST_IDLE;
        end
        default: next_r.st = ST_IDLE;
      endcase
      if (next_r.flag_lo == '0 && next_r.flag_hi == '0) next_r.alert = 1'b0;
    end
    // Registered oscillator status
    next_r.fast_osc = next_r.osc | (next_r.st == ST_MAN);
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '0;
      r.st <= ST_CAL;
      r.busy <= 1'b1;
      r.osc <= 1'b1;
      r.fast_osc <= 1'b1;
      r.seq_ch <= ams_pkg::SEQ_CH_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Outputs
  assign lnk.rdata      = r.rdata;
  assign lnk.scl_hold   = r.scl_hold;
  assign lnk.sample_vld = r.sample_vld;
  assign lnk.sample_ch  = r.sample_ch;
  assign lnk.sample     = r.sample;
  assign lnk.busy       = r.busy;
  assign lnk.alert      = r.alert;
  assign fast_osc_used  = r.fast_osc;
endmodule
`default_nettype wire

// ===== src/ams_host.sv
`timescale 1ns/100ps
`default_nettype none
module ams_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Link to device
  ams_link_if.host         lnk,
  // User command port
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [3:0]  cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  input  wire logic        cmd_gc,
  input  wire logic        cmd_pwr,
  input  wire logic        cmd_read_run,
  input  wire logic        cmd_stop,
  // Results
  output logic [7:0]       rd_data,
  output logic             res_vld,
  output logic [11:0]      res,
  output logic             dev_busy
);
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        gc;
    logic [7:0]  gbyte;
    logic        pwr;
    logic        drd;
    logic        nack;
    logic        run;
    logic        scl_low;
    logic [7:0]  hc;
    logic [7:0]  rdd;
    logic        rd_q;
    logic        vld;
    logic [11:0] res;
    logic        busy;
  } ams_host_t;
  ams_host_t r;
  ams_host_t next_r;

  // Drive transactions, pace SCL, honour stretching
  always_comb begin
    next_r = r;
    next_r.wr = cmd_wr;
    next_r.rd = cmd_rd;
    next_r.addr = cmd_addr;
    next_r.wdata = cmd_wdata;
    next_r.gc = cmd_gc;
    next_r.gbyte = ams_pkg::SOFT_RESET_BYTE;
    next_r.pwr = cmd_pwr;
    next_r.drd = cmd_read_run;
    next_r.nack = cmd_stop;
    next_r.rd_q = r.rd;
    next_r.vld = lnk.sample_vld;
    next_r.busy = lnk.busy;
    if (r.rd_q) next_r.rdd = lnk.rdata;
    if (lnk.sample_vld) next_r.res = lnk.sample;
    if (cmd_read_run) next_r.run = 1'b1;
    if (cmd_stop) next_r.run = 1'b0;
    next_r.hc = r.hc + 8'h01;
    if (!r.run) begin
      next_r.scl_low = 1'b0;
      next_r.hc = '0;
    end else if (r.hc >= 8'(ams_pkg::HOST_SCL_HALF) && !lnk.scl_hold) begin
      next_r.scl_low = !r.scl_low;
      next_r.hc = '0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign lnk.wr          = r.wr;
  assign lnk.rd          = r.rd;
  assign lnk.addr        = r.addr;
  assign lnk.wdata       = r.wdata;
  assign lnk.gen_call    = r.gc;
  assign lnk.gen_byte    = r.gbyte;
  assign lnk.power_cycle = r.pwr;
  assign lnk.data_rd     = r.drd;
  assign lnk.nack_stop   = r.nack;
  assign lnk.scl_low     = r.scl_low;
  assign rd_data         = r.rdd;
  assign res_vld         = r.vld;
  assign res             = r.res;
  assign dev_busy        = r.busy;
endmodule
`default_nettype wire

// ===== src/ams_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// Abstract link: host transactions and the device's answers
interface ams_link_if;
  logic       power_cycle;  // Analog supply recycled
  logic       gen_call;     // General call with command byte
  logic [7:0] gen_byte;
  logic       wr;           // Register write pulse
  logic       rd;           // Register read pulse
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       data_rd;      // Address+read: start manual conversions
  logic       nack_stop;    // NACK then STOP
  logic       scl_low;      // Host drives SCL low
  logic       scl_hold;     // Device stretches SCL
  logic       sample_vld;   // Result returned to host
  logic       sample_ch;
  logic [11:0] sample;
  logic       busy;
  logic       alert;
  modport dev  (input power_cycle, gen_call, gen_byte, wr, rd, addr, wdata, data_rd,
                nack_stop, scl_low,
                output rdata, scl_hold, sample_vld, sample_ch, sample, busy, alert);
  modport host (output power_cycle, gen_call, gen_byte, wr, rd, addr, wdata, data_rd,
                nack_stop, scl_low,
                input rdata, scl_hold, sample_vld, sample_ch, sample, busy, alert);
endinterface
`default_nettype wire

// ===== src/ams_pkg.sv
package ams_pkg;
  // Operating mode select encodings
  localparam logic [2:0] MODE_MAN_CH0_A  = 3'h0;
  localparam logic [2:0] MODE_MAN_CH0_B  = 3'h1;
  localparam logic [2:0] MODE_MAN_SEQ_A  = 3'h4;
  localparam logic [2:0] MODE_MAN_SEQ_B  = 3'h5;
  localparam logic [2:0] MODE_AUTONOMOUS = 3'h6;
  // Bus command codes
  localparam logic [7:0] GENERAL_CALL    = 8'h00;
  localparam logic [7:0] SOFT_RESET_BYTE = 8'h06;
  localparam logic [7:0] FLAG_CLEAR_VAL  = 8'h03;
  // Register indices on the link
  localparam logic [3:0] REG_MODE        = 4'h0;
  localparam logic [3:0] REG_SEQ_CH      = 4'h1;
  localparam logic [3:0] REG_SEQUENCE_START_BIT   = 4'h2;
  localparam logic [3:0] REG_SEQUENCE_ABORT_BIT   = 4'h3;
  localparam logic [3:0] REG_OSC         = 4'h4;
  localparam logic [3:0] REG_DIV         = 4'h5;
  localparam logic [3:0] REG_BUF_MODE    = 4'h6;
  localparam logic [3:0] REG_CMP_EN      = 4'h7;
  localparam logic [3:0] REG_ALERT_CH    = 4'h8;
  localparam logic [3:0] REG_THR_HI      = 4'h9;
  localparam logic [3:0] REG_THR_LO      = 4'ha;
  localparam logic [3:0] REG_HYS         = 4'hb;
  localparam logic [3:0] REG_FLAG_LO     = 4'hc;
  localparam logic [3:0] REG_FLAG_HI     = 4'hd;
  localparam logic [3:0] REG_WRITE_KEY   = 4'he;
  localparam logic [3:0] REG_DEV_RESET   = 4'hf;
  localparam logic [7:0] WRITE_KEY_VAL   = 8'h0a;
  // Reset values
  localparam logic [1:0] SEQ_CH_RESET    = 2'h1;
  // Timing
  localparam int CLK_MHZ          = 100;
  localparam int SCL_LOW_MIN_NS   = 1800;
  localparam int SCL_LOW_MIN_CYC  = (SCL_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_TIME_NS      = 2000;
  localparam int CAL_CYC          = (CAL_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int AUTO_PERIOD_CYC  = 64;
  localparam int STD_SCL_PERIOD_NS = 10000;
  localparam int STD_SCL_CYC      = STD_SCL_PERIOD_NS * CLK_MHZ / 1000;
  localparam int HOST_SCL_HALF    = 40;
  localparam int BUF_DEPTH        = 16;
endpackage

// ===== tb/ams_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ams_monitor (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Host side of the link
  input wire logic       power_cycle,
  input wire logic       gen_call,
  input wire logic [7:0] gen_byte,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       scl_low,
  // Device side of the link
  input wire logic       scl_hold,
  input wire logic       sample_vld,
  input wire logic       busy,
  input wire logic       alert
);
  localparam int LOWCYC = ams_pkg::SCL_LOW_MIN_CYC;
  logic [9:0] low_cnt;
  logic       cmp_on;
  // Cycles since SCL went low; last comparator enable written
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_cnt <= 10'h000;
      cmp_on  <= 1'b0;
    end else begin
      low_cnt <= $rose(scl_low) ? 10'h000 : low_cnt + {9'h000, low_cnt != 10'h3ff};
      if (wr && addr == ams_pkg::REG_CMP_EN) begin
        cmp_on <= |wdata;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence full_rst_s;
    power_cycle || (gen_call && gen_byte == ams_pkg::SOFT_RESET_BYTE);
  endsequence
  // SCL released, then a result returned for that low phase
  sequence low_done_s;
    $fell(scl_low) ##1 sample_vld;
  endsequence
  a_busy_from_reset: assert property ($rose(rstn) |-> busy [*8])
    else $error("busy not high after reset");
  a_no_sample_busy: assert property (busy |-> !sample_vld)
    else $error("sample returned during calibration");
  a_full_reset_cal: assert property (full_rst_s |-> ##[1:3] busy)
    else $error("full reset did not recalibrate");
  a_soft_no_cal: assert property ((wr && addr == ams_pkg::REG_DEV_RESET && !busy) |-> ##1 !busy [*8])
    else $error("soft reset started calibration");
  a_sample_single: assert property (sample_vld |=> !sample_vld)
    else $error("sample valid longer than one cycle");
  a_stretch_short: assert property (low_done_s |-> low_cnt >= LOWCYC)
    else $error("SCL low before a sample shorter than minimum");
  a_stretch_bound: assert property (scl_hold |-> low_cnt <= LOWCYC + 2)
    else $error("SCL stretched past minimum low time");
  a_read_aborts: assert property (rd |-> ##2 !sample_vld [*8])
    else $error("sample after register read");
  a_alert_enabled: assert property ($rose(alert) |-> cmp_on)
    else $error("alert without comparator enable");
  a_alert_halts: assert property (alert |-> !sample_vld)
    else $error("conversion after alert");
  a_flag_clear: assert property ((wr && addr == ams_pkg::REG_FLAG_HI
    && wdata == ams_pkg::FLAG_CLEAR_VAL) |-> ##[1:3] !alert)
    else $error("alert kept after flag clear");
endmodule
`default_nettype wire

// ===== tb/tb_adc_mode_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_adc_mode_sequencer;
  logic        clk, rstn, wr, rd, gc, pwr, run, stp, fast, vld, bsy;
  logic [3:0]  ad;
  logic [7:0]  wd, rdd, d;
  logic [11:0] in0, in1, res;
  int          error_cnt, n_tests, seed, nxt_ch, alt, n_smp, n, mdl[16];
  ams_link_if lnk ();
  ams_device ams_device_i (.clk(clk), .rstn(rstn), .lnk(lnk.dev), .adc_in0(in0),
    .adc_in1(in1), .fast_osc_used(fast));
  ams_host ams_host_i (.clk(clk), .rstn(rstn), .lnk(lnk.host), .cmd_wr(wr), .cmd_rd(rd),
    .cmd_addr(ad), .cmd_wdata(wd), .cmd_gc(gc), .cmd_pwr(pwr), .cmd_read_run(run),
    .cmd_stop(stp), .rd_data(rdd), .res_vld(vld), .res(res), .dev_busy(bsy));
  ams_monitor ams_monitor_i (.clk(clk), .rstn(rstn), .power_cycle(lnk.power_cycle),
    .gen_call(lnk.gen_call), .gen_byte(lnk.gen_byte), .wr(lnk.wr), .rd(lnk.rd),
    .addr(lnk.addr), .wdata(lnk.wdata), .scl_low(lnk.scl_low), .scl_hold(lnk.scl_hold),
    .sample_vld(lnk.sample_vld), .busy(lnk.busy), .alert(lnk.alert));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict();
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic pulse(input logic [3:0] w);
    @(posedge clk);
    {run, stp, gc, pwr} <= w;
    @(posedge clk);
    {run, stp, gc, pwr} <= 4'h0;
    cyc(2);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    ad <= a;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
    cyc(2);
    mdl[a] = v;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    ad <= a;
    @(posedge clk);
    rd <= 1'b0;
    cyc(3);
    d = rdd;
  endtask
  task automatic chk_reg(input logic [3:0] a);
    rreg(a);
    chk("register", 12'(mdl[a]), {4'h0, d});
  endtask
  // Bounded wait on alert or busy
  task automatic wait_lvl(input bit sel, input logic v);
    for (int i = 0; i < 3000 && (sel ? lnk.alert : bsy) !== v; i++)
      @(posedge clk);
    chk(sel ? "alert" : "busy", {11'h000, v}, {11'h000, sel ? lnk.alert : bsy});
    if ((sel ? lnk.alert : bsy) !== v)
      give_verdict();
  endtask
  // Start a manual read and collect k results
  task automatic run_cap(input int k, input int two);
    nxt_ch = 0;
    alt = two;
    n = n_smp + k;
    pulse(4'h8);
    for (int i = 0; i < 8000 && n_smp < n; i++)
      @(posedge clk);
    chk("samples", 12'(n), 12'(n_smp));
    chk("fast_osc", 12'h001, {11'h000, fast});
    if (n_smp < n)
      give_verdict();
  endtask
  // Reference model of returned results
  always @(posedge clk) begin
    if (vld === 1'b1) begin
      chk("sample", nxt_ch ? in1 : in0, res);
      chk("sample_ch", 12'(nxt_ch), {11'h000, lnk.sample_ch});
      nxt_ch = alt ? 1 - nxt_ch : 0;
      n_smp++;
    end
  end
  initial begin
    seed = 81916;
    {rstn, wr, rd, gc, pwr, run, stp} = 7'h00;
    ad = 4'h0;
    wd = 8'h00;
    in0 = 12'($random(seed));
    in1 = in0 ^ 12'h800;
    foreach (mdl[i]) mdl[i] = 0;
    mdl[ams_pkg::REG_SEQ_CH] = ams_pkg::SEQ_CH_RESET;
    cyc(8);
    rstn <= 1'b1;
    cyc(3);
    chk("busy", 12'h001, {11'h000, bsy});
    wait_lvl(0, 1'b0);
    chk_reg(ams_pkg::REG_SEQ_CH);
    wreg(ams_pkg::REG_HYS, 8'($random(seed)));
    wreg(ams_pkg::REG_DEV_RESET, 8'h01);
    chk_reg(ams_pkg::REG_HYS);
    // Oscillator choice off: manual mode must still use the fast one
    for (int m = 0; m < 2; m++) begin
      wreg(ams_pkg::REG_DIV, 8'($random(seed)));
      wreg(ams_pkg::REG_OSC, 8'h00);
      wreg(ams_pkg::REG_MODE, 8'(m));
      run_cap(4, 0);
      pulse(4'h4);
    end
    for (int m = 4; m < 6; m++) begin
      wreg(ams_pkg::REG_MODE, 8'(m));
      wreg(ams_pkg::REG_SEQ_CH, 8'h03);
      wreg(ams_pkg::REG_SEQUENCE_START_BIT, 8'h01);
      run_cap(5, 1);
      chk_reg(ams_pkg::REG_SEQ_CH);
      n = n_smp;
      cyc(800);
      chk("after_read", 12'(n), 12'(n_smp));
      wreg(ams_pkg::REG_SEQUENCE_ABORT_BIT, 8'h01);
      pulse(4'h4);
    end
    wreg(ams_pkg::REG_HYS, 8'($random(seed)));
    wreg(ams_pkg::REG_WRITE_KEY, ams_pkg::WRITE_KEY_VAL);
    wreg(ams_pkg::REG_DEV_RESET, 8'h01);
    chk("busy", 12'h000, {11'h000, bsy});
    mdl[ams_pkg::REG_HYS] = 0;
    mdl[ams_pkg::REG_SEQ_CH] = ams_pkg::SEQ_CH_RESET;
    chk_reg(ams_pkg::REG_HYS);
    chk_reg(ams_pkg::REG_SEQ_CH);
    for (int w = 1; w < 3; w++) begin
      wreg(ams_pkg::REG_HYS, 8'($random(seed)));
      pulse(4'(w));
      // Busy copy in the host lags the device by one more edge
      cyc(1);
      chk("busy", 12'h001, {11'h000, bsy});
      wait_lvl(0, 1'b0);
      mdl[ams_pkg::REG_HYS] = 0;
      chk_reg(ams_pkg::REG_HYS);
    end
    in0 <= 12'hf00;
    wreg(ams_pkg::REG_MODE, 8'(ams_pkg::MODE_AUTONOMOUS));
    wreg(ams_pkg::REG_SEQ_CH, 8'h01);
    wreg(ams_pkg::REG_THR_HI, 8'h10);
    wreg(ams_pkg::REG_ALERT_CH, 8'h01);
    wreg(ams_pkg::REG_SEQUENCE_START_BIT, 8'h01);
    cyc(400);
    chk("alert", 12'h000, {11'h000, lnk.alert});
    wreg(ams_pkg::REG_SEQUENCE_ABORT_BIT, 8'h01);
    wreg(ams_pkg::REG_CMP_EN, 8'h01);
    wreg(ams_pkg::REG_SEQUENCE_START_BIT, 8'h01);
    wait_lvl(1, 1'b1);
    rreg(ams_pkg::REG_FLAG_HI);
    chk("flag_hi", 12'h001, {11'h000, d[0]});
    wreg(ams_pkg::REG_FLAG_HI, ams_pkg::FLAG_CLEAR_VAL);
    rreg(ams_pkg::REG_FLAG_HI);
    chk("flag_hi", 12'h000, {4'h0, d});
    chk("alert", 12'h000, {11'h000, lnk.alert});
    give_verdict();
  end
endmodule
`default_nettype wire
